// ### core/fsz_top.sv
// Overview of operation
// - with two zones enabled the output may stay on if either zone is 1, stop only if both are 0.
// - all inputs selected in one column are ANDed into that column's zone result.
// - each column's mask is evaluated on its own, never touching the other column.
// - a download selecting an unconfigured input is rejected and flagged as a failure.
// - a selected input going inactive or into error forces the output off at once, unless two zones are enabled and the other zone is 1.
// - an input counts as inactive only after its configured off delay has run out.
// - after a trip the output stays off until causes are active again and control went off first.
// - selected inputs are active high; an inactive level trips, whether or not the input was active before.
`timescale 1ns/100ps
`default_nettype none
`include "fsz_regs.svh"
module fsz_top
  import fsz_pkg::*;
#(
  parameter int N = 14,
  parameter int DW = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [N-1:0] in_pins,
  input wire logic [N-1:0] in_err,
  input wire logic ctl_out,
  output logic out_drv,
  output logic fail
);
  // ****************************************
  // registers
  // ****************************************
  logic two_zone_r;
  logic [N-1:0] mask_a_r;
  logic [N-1:0] mask_b_r;
  logic [N-1:0] cfg_ok_r;
  logic [N-1:0] stage_a_r;
  logic [N-1:0] stage_b_r;
  logic [DW-1:0] dly_r [N];
  logic [N-1:0] act;
  logic ctl_s1_r;
  logic ctl_s2_r;
  logic ctl_s3_r;
  logic perm;
  logic latch_r;
  fsz_state_t st_r;
  logic wr;
  logic rd;
  logic [N-1:0] sel_mask;
  logic [31:0] rd_nxt;
  logic unmapped;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  // register index of a delay slot, or -1 if outside the table
  function automatic int dly_idx(input logic [11:0] a);
    int i;
    i = -1;
    if (a >= `FSZ_DLY_BASE_OFS && a < `FSZ_DLY_BASE_OFS + 12'(4 * N) && a[1:0] == 2'b00)
    begin
      i = int'((a - `FSZ_DLY_BASE_OFS) >> 2);
    end
    return i;
  endfunction

  // ****************************************
  // configuration writes and download check
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      two_zone_r <= 1'b0;
      mask_a_r <= '0;
      mask_b_r <= '0;
      stage_a_r <= '0;
      stage_b_r <= '0;
      cfg_ok_r <= '0;
      fail <= 1'b0;
    end
    else if (wr)
    begin
      case (paddr)
        `FSZ_CTRL_OFS:
        begin
          two_zone_r <= pwdata[`FSZ_CTRL_TWOZ_BIT];
          if (pwdata[`FSZ_CTRL_LOAD_BIT])
          begin
            // download: commit staged masks only if every selected input is configured
            if (((stage_a_r | stage_b_r) & ~cfg_ok_r) != '0)
            begin
              fail <= 1'b1;
            end
            else
            begin
              mask_a_r <= stage_a_r;
              mask_b_r <= stage_b_r;
              fail <= 1'b0;
            end
          end
        end
        `FSZ_MASK_A_OFS: stage_a_r <= pwdata[N-1:0];
        `FSZ_MASK_B_OFS: stage_b_r <= pwdata[N-1:0];
        `FSZ_CFGOK_OFS: cfg_ok_r <= pwdata[N-1:0];
        default:
        begin
        end
      endcase
    end
  end

  // per-input off delay registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < N; i++)
      begin
        dly_r[i] <= `FSZ_DLY_RST;
      end
    end
    else if (wr && dly_idx(paddr) >= 0)
    begin
      dly_r[dly_idx(paddr)] <= pwdata[DW-1:0];
    end
  end

  // ****************************************
  // input conditioning
  // ****************************************
  for (genvar g = 0; g < N; g++)
  begin : g_ch
    fsz_chan #(.DW(DW)) u_ch
    (
      .pclk(pclk),
      .presetn(presetn),
      .in_pin(in_pins[g]),
      .err_pin(in_err[g]),
      .off_dly(dly_r[g]),
      .act(act[g])
    );
  end

  // normal output control, synchronised
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_s1_r <= 1'b0;
      ctl_s2_r <= 1'b0;
      ctl_s3_r <= 1'b0;
    end
    else
    begin
      ctl_s1_r <= ctl_out;
      ctl_s2_r <= ctl_s1_r;
      ctl_s3_r <= ctl_s2_r;
    end
  end

  // ****************************************
  // zone logic and interlock
  // ****************************************
  // each column ANDs its own selected inputs, unselected bits count as 1
  always_comb
  begin
    logic za;
    logic zb;
    za = &(act | ~mask_a_r);
    zb = &(act | ~mask_b_r);
    perm = two_zone_r ? (za | zb) : za;
  end

  assign sel_mask = two_zone_r ? (mask_a_r | mask_b_r) : mask_a_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= FSZ_RUN;
      out_drv <= 1'b0;
      latch_r <= 1'b0;
    end
    else
    begin
      case (st_r)
        FSZ_RUN:
        begin
          if (!perm)
          begin
            st_r <= FSZ_TRIP;
            out_drv <= 1'b0;
            latch_r <= 1'b1;
          end
          else if (ctl_s3_r == ctl_s2_r)
          begin
            out_drv <= ctl_s3_r; // follow control only once stages 2 and 3 agree
          end
        end
        FSZ_TRIP:
        begin
          out_drv <= 1'b0;
          if (!(ctl_s3_r && ctl_s2_r))
          begin
            st_r <= FSZ_WAIT_CTL;
          end
        end
        FSZ_WAIT_CTL:
        begin
          out_drv <= 1'b0;
          if (!perm)
          begin
            st_r <= FSZ_TRIP;
          end
          else if (!ctl_s3_r && !ctl_s2_r)
          begin
            st_r <= FSZ_RUN;
            latch_r <= 1'b0;
          end
        end
        default:
        begin
          st_r <= FSZ_TRIP;
          out_drv <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // apb read path, zero wait states
  // ****************************************
  always_comb
  begin
    unmapped = 1'b0;
    rd_nxt = 32'h0000_0000;
    case (paddr)
      `FSZ_CTRL_OFS: rd_nxt[`FSZ_CTRL_TWOZ_BIT] = two_zone_r;
      `FSZ_MASK_A_OFS: rd_nxt[N-1:0] = mask_a_r;
      `FSZ_MASK_B_OFS: rd_nxt[N-1:0] = mask_b_r;
      `FSZ_CFGOK_OFS: rd_nxt[N-1:0] = cfg_ok_r;
      `FSZ_STAT_OFS:
      begin
        rd_nxt[`FSZ_STAT_PERM_BIT] = perm;
        rd_nxt[`FSZ_STAT_LATCH_BIT] = latch_r;
        rd_nxt[`FSZ_STAT_FAIL_BIT] = fail;
        rd_nxt[`FSZ_STAT_OUT_BIT] = out_drv;
        rd_nxt[16 +: N] = act & sel_mask;
      end
      default:
      begin
        if (dly_idx(paddr) >= 0)
        begin
          rd_nxt[DW-1:0] = dly_r[dly_idx(paddr)];
        end
        else
        begin
          unmapped = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && unmapped;
      if (rd)
      begin
        prdata <= rd_nxt;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_trip_off;
    @(posedge pclk) disable iff (!presetn)
    (st_r == FSZ_RUN && !perm) |=> !out_drv && st_r == FSZ_TRIP;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("output not dropped on trip");

  property p_off_latched;
    @(posedge pclk) disable iff (!presetn)
    (st_r != FSZ_RUN) |=> !out_drv;
  endproperty
  a_off_latched: assert property (p_off_latched) else $error("output on while latched");

  property p_rearm;
    @(posedge pclk) disable iff (!presetn)
    ($past(st_r) != FSZ_RUN && st_r == FSZ_RUN) |-> $past(perm) && !$past(ctl_s3_r);
  endproperty
  a_rearm: assert property (p_rearm) else $error("rearm without interlock");

  property p_or_two;
    @(posedge pclk) disable iff (!presetn)
    two_zone_r |-> perm == (&(act | ~mask_a_r) || &(act | ~mask_b_r));
  endproperty
  a_or_two: assert property (p_or_two) else $error("two zone or wrong");

  property p_one_zone;
    @(posedge pclk) disable iff (!presetn)
    !two_zone_r |-> perm == &(act | ~mask_a_r);
  endproperty
  a_one_zone: assert property (p_one_zone) else $error("single zone wrong");

  property p_and_col;
    @(posedge pclk) disable iff (!presetn)
    ((mask_a_r & ~act) != '0 && !two_zone_r) |-> !perm;
  endproperty
  a_and_col: assert property (p_and_col) else $error("column and wrong");

  property p_col_indep;
    @(posedge pclk) disable iff (!presetn)
    (two_zone_r && (mask_a_r & ~act) == '0) |-> perm;
  endproperty
  a_col_indep: assert property (p_col_indep) else $error("column b affected a");

  property p_reject;
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == `FSZ_CTRL_OFS && pwdata[`FSZ_CTRL_LOAD_BIT]
      && ((stage_a_r | stage_b_r) & ~cfg_ok_r) != '0)
      |=> fail && $stable(mask_a_r) && $stable(mask_b_r);
  endproperty
  a_reject: assert property (p_reject) else $error("bad download accepted");

  c_trip: cover property (@(posedge pclk) disable iff (!presetn) st_r == FSZ_TRIP);
  c_rearm: cover property (@(posedge pclk) disable iff (!presetn)
    st_r == FSZ_WAIT_CTL ##1 st_r == FSZ_RUN);
  c_fail: cover property (@(posedge pclk) disable iff (!presetn) $rose(fail));
  c_or: cover property (@(posedge pclk) disable iff (!presetn) two_zone_r && perm
    && (mask_a_r & ~act) != '0);
endmodule
`default_nettype wire

// ### core/fsz_regs.svh
`ifndef FSZ_REGS_SVH
`define FSZ_REGS_SVH
// register byte offsets
`define FSZ_CTRL_OFS 12'h000
`define FSZ_MASK_A_OFS 12'h004
`define FSZ_MASK_B_OFS 12'h008
`define FSZ_CFGOK_OFS 12'h00C
`define FSZ_STAT_OFS 12'h010
`define FSZ_DLY_BASE_OFS 12'h040
// control register fields
`define FSZ_CTRL_TWOZ_BIT 0
`define FSZ_CTRL_LOAD_BIT 1
// status register fields
`define FSZ_STAT_PERM_BIT 0
`define FSZ_STAT_LATCH_BIT 1
`define FSZ_STAT_FAIL_BIT 2
`define FSZ_STAT_OUT_BIT 3
// reset values
`define FSZ_MASK_RST 32'h0000_0000
`define FSZ_DLY_RST 16'h0000
`endif

// ### core/fsz_pkg.sv
package fsz_pkg;
  typedef enum logic [1:0] {FSZ_RUN, FSZ_TRIP, FSZ_WAIT_CTL} fsz_state_t;
endpackage

// ### core/fsz_chan.sv
`timescale 1ns/100ps
`default_nettype none
`include "fsz_regs.svh"
// ****************************************
// per-input synchroniser and off delay
// ****************************************
module fsz_chan
  import fsz_pkg::*;
#(
  parameter int DW = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_pin,
  input wire logic err_pin,
  input wire logic [DW-1:0] off_dly,
  output logic act
);
  logic [2:0] s_r;
  logic [2:0] e_r;
  logic [DW-1:0] cnt_r;
  // three-stage synchronisers, change accepted when stages 2 and 3 agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= 3'b000;
      e_r <= 3'b111;
    end
    else
    begin
      s_r <= {s_r[1:0], in_pin};
      e_r <= {e_r[1:0], err_pin};
    end
  end
  // active high input; inactive only after the off delay, error drops at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act <= 1'b0;
      cnt_r <= '0;
    end
    else if (e_r[2] && e_r[1])
    begin
      act <= 1'b0;
      cnt_r <= '0;
    end
    else if (s_r[2] && s_r[1] && !e_r[2] && !e_r[1])
    begin
      act <= 1'b1;
      cnt_r <= '0;
    end
    else if (!s_r[2] && !s_r[1] && act)
    begin
      if (cnt_r >= off_dly)
      begin
        act <= 1'b0;
        cnt_r <= '0;
      end
      else
      begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/fsz_field_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// field side: sensors and output control
// ****************************************
module fsz_field_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [13:0] req_pins,
  input wire logic [13:0] req_err,
  input wire logic req_ctl,
  output logic [13:0] in_pins,
  output logic [13:0] in_err,
  output logic ctl_out
);
  // field levels follow the bench request one edge later, quiet in reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_pins <= 14'h0000;
      in_err <= 14'h0000;
      ctl_out <= 1'b0;
    end
    else
    begin
      in_pins <= req_pins;
      in_err <= req_err;
      ctl_out <= req_ctl;
    end
  end
endmodule
`default_nettype wire

// ### dv/fast_shutoff_zone_logic_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "fsz_regs.svh"
module fast_shutoff_zone_logic_tb;
  localparam logic [13:0] ALL = 14'h3FFF;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic ctl_out, out_drv, fail, rq_ctl, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [13:0] in_pins, in_err, rq_pins, rq_err;
  logic [13:0] rows [3];
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int i;
  // ****************************************
  // design and field model
  // ****************************************
  fsz_top #(.N(14), .DW(16)) i_fsz_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_pins(in_pins), .in_err(in_err),
    .ctl_out(ctl_out), .out_drv(out_drv), .fail(fail));
  fsz_field_model i_fsz_field_model (.pclk(pclk), .presetn(presetn), .req_pins(rq_pins),
    .req_err(rq_err), .req_ctl(rq_ctl), .in_pins(in_pins), .in_err(in_err),
    .ctl_out(ctl_out));
  // ****************************************
  // clock, timeout and tasks
  // ****************************************
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      end_sim();
    end
  end
  task end_sim();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no assumed latency: only the hang guard ends this wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk("pslverr", e, 0);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 0);
    chk("prdata", q, exp);
  endtask
  task setp(input logic [13:0] p, input logic [13:0] er, input logic c);
    @(posedge pclk);
    rq_pins <= p;
    rq_err <= er;
    rq_ctl <= c;
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // bounded wait for the driver level
  task wout(input logic v);
    int n;
    n = 0;
    while (out_drv !== v && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    chk("out_drv", out_drv, v);
  endtask
  // restore causes; control must drop before the output returns
  task recov();
    setp(ALL, 0, 1);
    wt(20);
    chk("out_drv held", out_drv, 0);
    setp(ALL, 0, 0);
    wt(10);
    setp(ALL, 0, 1);
    wout(1);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rq_pins = ALL;
    rq_err = 14'h0000;
    rq_ctl = 1'b0;
    rows = '{14'h0001, 14'h0004, 14'h0000};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`FSZ_MASK_A_OFS, `FSZ_MASK_RST);
    rd(`FSZ_DLY_BASE_OFS, {16'h0000, `FSZ_DLY_RST});
    apb(1'b0, 12'h0FC, 0);
    chk("unmapped err", e, 1);
    chk("unmapped data", q, 0);
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    chk("unmapped werr", e, 1);
    // e-stop on input 4 in both columns, dual pair 0/2 uses channel 0 in column A and channel 2 in column B
    wr(`FSZ_CFGOK_OFS, 32'h0000_3FFF);
    wr(`FSZ_MASK_A_OFS, 32'h0000_0011);
    wr(`FSZ_MASK_B_OFS, 32'h0000_0014);
    wr(`FSZ_CTRL_OFS, 32'h0000_0003);
    setp(ALL, 0, 1);
    wout(1);
    for (i = 0; i < 3; i++)
    begin
      setp(ALL & ~rows[i], 0, 1);
      wt(20);
      chk("zone or", out_drv, 1);
    end
    setp(ALL & ~14'h0005, 0, 1);
    wout(0);
    setp(ALL, 0, 1);
    wt(20);
    rd(`FSZ_STAT_OFS, 32'h0015_0003);
    recov();
    setp(ALL & ~14'h0010, 0, 1);
    wout(0);
    recov();
    wr(`FSZ_MASK_B_OFS, 32'h0000_0004);
    wr(`FSZ_CTRL_OFS, 32'h0000_0003);
    setp(ALL & ~14'h0010, 0, 1);
    wt(20);
    chk("column apart", out_drv, 1);
    // restore input 4 first, else dropping to one zone trips on column one
    setp(ALL, 0, 1);
    wt(10);
    wr(`FSZ_CTRL_OFS, 32'h0000_0002);
    setp(ALL & ~14'h0004, 0, 1);
    wt(20);
    chk("one zone", out_drv, 1);
    setp(ALL & ~14'h0001, 0, 1);
    wout(0);
    recov();
    rd(`FSZ_STAT_OFS, 32'h0011_0009);
    setp(ALL, 14'h0001, 1);
    wout(0);
    recov();
    wr(`FSZ_DLY_BASE_OFS, 32'h0000_001E);
    wr(`FSZ_CTRL_OFS, 32'h0000_0002);
    setp(ALL & ~14'h0001, 0, 1);
    wt(20);
    chk("off delay", out_drv, 1);
    wout(0);
    recov();
    wr(`FSZ_CFGOK_OFS, 32'h0000_3FEF);
    wr(`FSZ_CTRL_OFS, 32'h0000_0003);
    wt(5);
    chk("fail", fail, 1);
    rd(`FSZ_STAT_OFS, 32'h0015_000D);
    wr(`FSZ_CFGOK_OFS, 32'h0000_3FFF);
    wr(`FSZ_CTRL_OFS, 32'h0000_0002);
    wt(5);
    chk("fail clear", fail, 0);
    end_sim();
  end
endmodule
`default_nettype wire
